// *** verilog/hrs_consts.svh ***
// Purpose: constants for the host response and special cycle block
// Assumes: included by bare name from design files
// Notes: response codes, special cycle encodings, queue entry layout
`ifndef HRS_CONSTS_SVH
`define HRS_CONSTS_SVH

// response status codes
`define HRS_RS_IDLE 3'h0
`define HRS_RS_RETRY 3'h1
`define HRS_RS_DEFER 3'h2
`define HRS_RS_RESERVED 3'h3
`define HRS_RS_HARD_FAIL 3'h4
`define HRS_RS_NO_DATA 3'h5
`define HRS_RS_IWB 3'h6
`define HRS_RS_NORMAL 3'h7

// special cycle request phase match
`define HRS_REQA_SPECIAL 5'h08
`define HRS_REQB_SPECIAL_LOW 3'h1

// special cycle type byte values
`define HRS_SC_NOP 8'h00
`define HRS_SC_SHUTDOWN 8'h01
`define HRS_SC_FLUSH 8'h02
`define HRS_SC_HALT 8'h03
`define HRS_SC_SYNC 8'h04
`define HRS_SC_FLUSH_ACK 8'h05
`define HRS_SC_STOP_CLK_ACK 8'h06
`define HRS_SC_MGMT_ACK 8'h07

// in-order queue
`define HRS_IOQ_DEPTH 4
`define HRS_ENT_W 8
`define HRS_ENT_CODE_MSB 2
`define HRS_ENT_CODE_LSB 0
`define HRS_ENT_FWD_MSB 4
`define HRS_ENT_FWD_LSB 3
`define HRS_ENT_SPECIAL 5
`define HRS_ENT_DATA 6
`define HRS_ENT_PROT 7

`endif

// *** verilog/hrs_pkg.sv ***
// Purpose: shared types for the host response and special cycle block
// Assumes: nothing
// Notes: enumerations only; numbers live in hrs_consts.svh
package hrs_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DECIDE,
        ST_HUB_REQ,
        ST_HUB_WAIT,
        ST_DATA_WAIT
    } hrs_state_t;

    typedef enum logic [1:0] {
        FWD_NONE,
        FWD_SHUTDOWN,
        FWD_HALT,
        FWD_STOP_GRANT
    } hrs_fwd_t;
endpackage

// *** verilog/hrs_ioq_mem.sv ***
// Purpose: storage for the in-order queue entries
// Assumes: one write and one read port on i_mclk
// Notes: read data come from a register, one cycle after the address
`timescale 1ns/1ps
`default_nettype none
module hrs_ioq_mem #(
    parameter int W = 8,
    parameter int DEPTH = 4,
    parameter int AW = 2
) (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // write port
    input wire logic i_we,
    input wire logic [AW-1:0] i_waddr,
    input wire logic [W-1:0] i_wdata,
    // read port
    input wire logic [AW-1:0] i_raddr,
    output logic [W-1:0] o_rdata
);
    logic [W-1:0] mem_reg [DEPTH];

    always_ff @(posedge i_mclk) begin
        if (i_we) begin
            mem_reg[i_waddr] <= i_wdata;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rdata <= '0;
        end else begin
            o_rdata <= mem_reg[i_raddr];
        end
    end
endmodule
`default_nettype wire

// *** verilog/hrs_host_resp.sv ***
// Purpose: response code selection and special cycle handling on the host bus
// Assumes: request attributes come decoded from logic on the same clock
// Notes: special cycles always answer with the no-data code
//
// Summary of operation
// (R01) Retry hub-bound reads/writes and locked memory reads when resource busy.
// (R02) Defer eligible hub and graphics reads and I/O writes on request.
// (R03) Writes and zero-length reads get the no-data code.
// (R04) Snoop hit on modified line gives implicit writeback code.
// (R05) Reads get normal data code, sent once read data is ready.
// (R06) Special cycle: first code 01000, second code low bits 001.
// (R07) Special type taken from second-phase byte; first address ignored.
// (R08) No-operation special cycle has no side effects.
// (R09) Shutdown forwarded downstream; retired after downstream master abort.
// (R10) Flush claimed and retired locally.
// (R11) Halt forwarded downstream; retired after downstream master abort.
// (R12) Sync claimed and retired locally.
// (R13) Flush acknowledge claimed and retired locally.
// (R14) Stop-clock acknowledge forwarded as stop-grant; retired after master abort.
// (R15) Management acknowledge with qualifier set opens protected space.
// (R16) Management acknowledge with qualifier clear closes protected space.
// (R17) Transactions are answered strictly in arrival order.
// (R18) Up to four outstanding requests are held in the in-order queue.
// (R19) Hard-failure and reserved codes are never driven.
// (R20) Undefined special types are claimed and retired without side effects.
`timescale 1ns/1ps
`default_nettype none
`include "hrs_consts.svh"
module hrs_host_resp
    import hrs_pkg::*;
#(
    parameter int IOQ_DEPTH = `HRS_IOQ_DEPTH
) (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_reset_n,
    // request phase
    input wire logic i_req_valid,
    output logic o_req_ready,
    input wire logic [4:0] i_first_request_phase_code,
    input wire logic [4:0] i_second_request_phase_code,
    input wire logic [7:0] i_second_phase_type_byte,
    input wire logic i_protected_space_qualifier,
    input wire logic i_req_read,
    input wire logic i_req_write,
    input wire logic i_req_zero_len,
    input wire logic i_req_io,
    input wire logic i_req_hub,
    input wire logic i_req_gfx,
    input wire logic i_req_locked,
    input wire logic i_req_busy,
    input wire logic i_req_defer,
    input wire logic i_snoop_hitm,
    // read data readiness
    input wire logic i_read_data_ready,
    // response phase
    output logic o_resp_valid,
    output logic [2:0] o_response_status_code,
    output logic o_resp_protected,
    // downstream special cycle
    output logic o_hub_sc_valid,
    output logic [1:0] o_hub_sc_kind,
    input wire logic i_hub_sc_ready,
    input wire logic i_hub_master_abort,
    // mode
    output logic o_protected_management_mode
);
    localparam int AW = $clog2(IOQ_DEPTH);
    localparam logic [AW:0] DEPTH_CNT = (AW+1)'(IOQ_DEPTH);
    localparam logic [AW-1:0] PTR_ONE = AW'(1);
    localparam logic [AW:0] CNT_ONE = (AW+1)'(1);

    logic rst_meta_reg;
    logic rst_n_sync;
    hrs_state_t state_reg;
    logic [AW-1:0] head_reg;
    logic [AW-1:0] tail_reg;
    logic [AW:0] count_reg;
    logic mode_reg;
    logic [1:0] fwd_reg;
    logic resp_valid_reg;
    logic [2:0] resp_code_reg;
    logic resp_prot_reg;
    logic req_take;
    logic req_special;
    logic finish;
    logic [2:0] push_code;
    hrs_fwd_t push_fwd;
    logic push_prot;
    logic [`HRS_ENT_W-1:0] push_ent;
    logic [`HRS_ENT_W-1:0] ioq_rdata;
    logic [2:0] ent_code;
    hrs_fwd_t ent_fwd;
    logic ent_special;
    logic ent_data;
    logic ent_prot;

    // reset release
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rst_meta_reg <= 1'b0;
            rst_n_sync <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n_sync <= rst_meta_reg;
        end
    end

    // response code chosen at request time; priority top to bottom
    function automatic logic [2:0] hrs_pick_code(
        input logic special, input logic hitm, input logic busy, input logic defer,
        input logic hub, input logic gfx, input logic locked, input logic rd,
        input logic wr, input logic zero, input logic io);
        logic retry_ok;
        logic defer_ok;
        retry_ok = busy && ((hub && (rd || wr)) || (locked && rd && !hub && !gfx)); // [R01]
        defer_ok = defer && (hub || gfx) && (rd || (wr && io)); // [R02]
        if (special) begin
            hrs_pick_code = `HRS_RS_NO_DATA;
        end else if (hitm) begin
            hrs_pick_code = `HRS_RS_IWB; // [R04]
        end else if (retry_ok) begin
            hrs_pick_code = `HRS_RS_RETRY; // [R01]
        end else if (defer_ok) begin
            hrs_pick_code = `HRS_RS_DEFER; // [R02]
        end else if (wr || zero || !rd) begin
            hrs_pick_code = `HRS_RS_NO_DATA; // [R03]
        end else begin
            hrs_pick_code = `HRS_RS_NORMAL; // [R05]
        end
    endfunction

    // only the type byte matters; the first address phase is never looked at
    function automatic hrs_fwd_t hrs_fwd_of(input logic [7:0] sc_type);
        case (sc_type)
            `HRS_SC_SHUTDOWN: hrs_fwd_of = FWD_SHUTDOWN; // [R07] [R09]
            `HRS_SC_HALT: hrs_fwd_of = FWD_HALT; // [R11]
            `HRS_SC_STOP_CLK_ACK: hrs_fwd_of = FWD_STOP_GRANT; // [R14]
            // nop, flush, sync, flush ack, mgmt ack and undefined stay local
            default: hrs_fwd_of = FWD_NONE; // [R08] [R10] [R12] [R13] [R20]
        endcase
    endfunction

    assign o_req_ready = (count_reg != DEPTH_CNT); // [R18]
    assign req_take = i_req_valid && o_req_ready;
    assign req_special = (i_first_request_phase_code == `HRS_REQA_SPECIAL)
        && (i_second_request_phase_code[2:0] == `HRS_REQB_SPECIAL_LOW); // [R06]

    always_comb begin
        push_code = hrs_pick_code(req_special, i_snoop_hitm, i_req_busy, i_req_defer,
            i_req_hub, i_req_gfx, i_req_locked, i_req_read, i_req_write,
            i_req_zero_len, i_req_io);
        push_fwd = req_special ? hrs_fwd_of(i_second_phase_type_byte) : FWD_NONE;
        push_prot = mode_reg && i_protected_space_qualifier && !req_special; // [R15]
        push_ent = {push_prot, (push_code == `HRS_RS_NORMAL), req_special, push_fwd,
            push_code};
    end

    hrs_ioq_mem #(
        .W(`HRS_ENT_W),
        .DEPTH(IOQ_DEPTH),
        .AW(AW)
    ) i_hrs_ioq_mem (
        .i_mclk(i_mclk),
        .i_rst_n(rst_n_sync),
        .i_we(req_take),
        .i_waddr(tail_reg),
        .i_wdata(push_ent),
        .i_raddr(head_reg),
        .o_rdata(ioq_rdata)
    );

    assign ent_code = ioq_rdata[`HRS_ENT_CODE_MSB:`HRS_ENT_CODE_LSB];
    assign ent_fwd = hrs_fwd_t'(ioq_rdata[`HRS_ENT_FWD_MSB:`HRS_ENT_FWD_LSB]);
    assign ent_special = ioq_rdata[`HRS_ENT_SPECIAL];
    assign ent_data = ioq_rdata[`HRS_ENT_DATA];
    assign ent_prot = ioq_rdata[`HRS_ENT_PROT];

    // head entry is retired this cycle
    always_comb begin
        case (state_reg)
            ST_DECIDE: finish = (ent_fwd == FWD_NONE) && !ent_data;
            ST_HUB_REQ: finish = i_hub_sc_ready && i_hub_master_abort; // [R09] [R11] [R14]
            ST_HUB_WAIT: finish = i_hub_master_abort; // [R09] [R11] [R14]
            ST_DATA_WAIT: finish = i_read_data_ready; // [R05]
            default: finish = 1'b0;
        endcase
    end

    // queue pointers; only the head is ever retired
    always_ff @(posedge i_mclk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            head_reg <= '0;
            tail_reg <= '0;
            count_reg <= '0;
        end else begin
            if (req_take) begin
                tail_reg <= tail_reg + PTR_ONE;
            end
            if (finish) begin
                head_reg <= head_reg + PTR_ONE; // [R17]
            end
            if (req_take && !finish) begin
                count_reg <= count_reg + CNT_ONE; // [R18]
            end else if (finish && !req_take) begin
                count_reg <= count_reg - CNT_ONE;
            end
        end
    end

    // sequencer; read data register needs one cycle after the head moves
    always_ff @(posedge i_mclk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            state_reg <= ST_IDLE;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (count_reg != '0) begin
                        state_reg <= ST_DECIDE;
                    end
                end
                ST_DECIDE: begin
                    if (ent_fwd != FWD_NONE) begin
                        state_reg <= ST_HUB_REQ; // [R09] [R11] [R14]
                    end else if (ent_data) begin
                        state_reg <= ST_DATA_WAIT; // [R05]
                    end else begin
                        state_reg <= ST_IDLE;
                    end
                end
                ST_HUB_REQ: begin
                    if (finish) begin
                        state_reg <= ST_IDLE;
                    end else if (i_hub_sc_ready) begin
                        state_reg <= ST_HUB_WAIT;
                    end
                end
                ST_HUB_WAIT: begin
                    if (finish) begin
                        state_reg <= ST_IDLE;
                    end
                end
                ST_DATA_WAIT: begin
                    if (finish) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    assign o_hub_sc_valid = (state_reg == ST_HUB_REQ);
    assign o_hub_sc_kind = fwd_reg;

    always_ff @(posedge i_mclk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            fwd_reg <= 2'h0;
        end else if (state_reg == ST_DECIDE) begin
            fwd_reg <= ent_fwd;
        end
    end

    // mode follows arrival order so later requests see it at once
    always_ff @(posedge i_mclk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            mode_reg <= 1'b0;
        end else if (req_take && req_special
            && (i_second_phase_type_byte == `HRS_SC_MGMT_ACK)) begin
            mode_reg <= i_protected_space_qualifier; // [R15] [R16]
        end
    end
    assign o_protected_management_mode = mode_reg;

    // response phase; only codes from the entry or idle ever reach the pins
    always_ff @(posedge i_mclk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            resp_valid_reg <= 1'b0;
            resp_code_reg <= `HRS_RS_IDLE;
            resp_prot_reg <= 1'b0;
        end else begin
            resp_valid_reg <= finish;
            resp_code_reg <= finish ? ent_code : `HRS_RS_IDLE; // [R19]
            resp_prot_reg <= finish && ent_prot;
        end
    end
    assign o_resp_valid = resp_valid_reg;
    assign o_response_status_code = resp_code_reg;
    assign o_resp_protected = resp_prot_reg;

    property p_code_legal;
        @(posedge i_mclk) disable iff (!rst_n_sync)
        o_resp_valid |-> !(o_response_status_code inside {`HRS_RS_HARD_FAIL, `HRS_RS_RESERVED,
            `HRS_RS_IDLE});
    endproperty
    a_code_legal: assert property (p_code_legal) else $error("illegal response code"); // [R19]

    property p_fwd_issue;
        @(posedge i_mclk) disable iff (!rst_n_sync)
        (state_reg == ST_DECIDE && ent_fwd != FWD_NONE)
            |=> o_hub_sc_valid && !o_resp_valid && (o_hub_sc_kind == $past(ent_fwd));
    endproperty
    a_fwd_issue: assert property (p_fwd_issue) else $error("special cycle not forwarded"); // [R09]

    property p_abort_retire;
        @(posedge i_mclk) disable iff (!rst_n_sync)
        (state_reg == ST_HUB_WAIT && i_hub_master_abort)
            |=> o_resp_valid && (o_response_status_code == `HRS_RS_NO_DATA);
    endproperty
    a_abort_retire: assert property (p_abort_retire) else $error("no retire after abort"); // [R11]

    property p_wait_abort;
        @(posedge i_mclk) disable iff (!rst_n_sync)
        (state_reg == ST_HUB_WAIT && !i_hub_master_abort) |=> !o_resp_valid;
    endproperty
    a_wait_abort: assert property (p_wait_abort) else $error("retired before abort"); // [R14]

    property p_local_special;
        @(posedge i_mclk) disable iff (!rst_n_sync)
        (state_reg == ST_DECIDE && ent_special && ent_fwd == FWD_NONE)
            |=> !o_hub_sc_valid && o_resp_valid && (o_response_status_code == `HRS_RS_NO_DATA);
    endproperty
    a_local_special: assert property (p_local_special) else $error("local special wrong"); // [R10]

    property p_mode_enter;
        @(posedge i_mclk) disable iff (!rst_n_sync)
        (req_take && req_special && i_second_phase_type_byte == `HRS_SC_MGMT_ACK
            && i_protected_space_qualifier) |=> o_protected_management_mode;
    endproperty
    a_mode_enter: assert property (p_mode_enter) else $error("space not opened"); // [R15]

    property p_mode_exit;
        @(posedge i_mclk) disable iff (!rst_n_sync)
        (req_take && req_special && i_second_phase_type_byte == `HRS_SC_MGMT_ACK
            && !i_protected_space_qualifier) |=> !o_protected_management_mode;
    endproperty
    a_mode_exit: assert property (p_mode_exit) else $error("protected space not closed"); // [R16]

    property p_nop_quiet;
        @(posedge i_mclk) disable iff (!rst_n_sync)
        (req_take && req_special && i_second_phase_type_byte == `HRS_SC_NOP)
            |=> $stable(o_protected_management_mode);
    endproperty
    a_nop_quiet: assert property (p_nop_quiet) else $error("nop changed mode"); // [R08]

    property p_depth;
        @(posedge i_mclk) disable iff (!rst_n_sync)
        (count_reg <= DEPTH_CNT) && (o_req_ready == (count_reg != DEPTH_CNT));
    endproperty
    a_depth: assert property (p_depth) else $error("queue depth broken"); // [R18]

    property p_in_order;
        @(posedge i_mclk) disable iff (!rst_n_sync)
        finish |=> (head_reg == $past(head_reg) + PTR_ONE) && o_resp_valid
            && (o_response_status_code == $past(ent_code));
    endproperty
    a_in_order: assert property (p_in_order) else $error("head out of order"); // [R17]

    property p_normal_data;
        @(posedge i_mclk) disable iff (!rst_n_sync)
        (o_resp_valid && o_response_status_code == `HRS_RS_NORMAL)
            |-> $past(state_reg) == ST_DATA_WAIT && $past(i_read_data_ready);
    endproperty
    a_normal_data: assert property (p_normal_data) else $error("data code without data"); // [R05]
endmodule
`default_nettype wire

// *** dv/hrs_hub_model.sv ***
// Purpose: downstream hub model that takes forwarded special cycles
// Assumes: drives 5 ns after the rising edge, like the bench
// Notes: always ends the cycle by master abort; i_slow stretches both waits
`timescale 1ns/1ps
`default_nettype none
module hrs_hub_model (
    // clock
    input wire logic i_mclk,
    // control
    input wire logic i_slow,
    // downstream special cycle
    input wire logic i_sc_valid,
    input wire logic [1:0] i_sc_kind,
    output logic o_sc_ready,
    output logic o_master_abort,
    // observation
    output logic [7:0] o_taken,
    output logic [1:0] o_kind_seen
);
    initial begin
        o_sc_ready = 1'b0;
        o_master_abort = 1'b0;
        o_taken = 8'h00;
        o_kind_seen = 2'h0;
        forever begin
            @(posedge i_mclk);
            if (i_sc_valid === 1'b1) begin
                repeat (i_slow ? 3 : 0) @(posedge i_mclk);
                #5 o_sc_ready = 1'b1;
                @(posedge i_mclk);
                o_kind_seen = i_sc_kind;
                o_taken = o_taken + 8'h01;
                #5 o_sc_ready = 1'b0;
                // no target claims it, so it always ends by master abort
                repeat (i_slow ? 4 : 1) @(posedge i_mclk);
                #5 o_master_abort = 1'b1;
                @(posedge i_mclk);
                #5 o_master_abort = 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// *** dv/tb_hrs_host_resp.sv ***
// Purpose: self-checking bench for the host response and special cycle block
// Assumes: 20 MHz clock, inputs driven 5 ns after the rising edge
// Notes: attribute vector is {rd, wr, zero, io, hub, gfx, locked, busy, defer, hitm}
`timescale 1ns/1ps
`default_nettype none
module tb_hrs_host_resp;
    logic i_mclk = 1'b0;
    logic i_reset_n = 1'b0;
    logic i_req_valid = 1'b0;
    logic [4:0] code_a = 5'h00;
    logic [4:0] code_b = 5'h00;
    logic [7:0] type_byte = 8'h00;
    logic qual = 1'b0;
    logic [9:0] at = 10'h000;
    logic data_ready = 1'b1;
    logic slow = 1'b0;
    logic req_ready, resp_valid, resp_prot, sc_valid, sc_ready, abort, mode;
    logic [2:0] rs_code;
    logic [1:0] sc_kind, kind_seen;
    logic [7:0] taken;
    int fail_count = 0;
    int checked = 0;

    always #25 i_mclk = ~i_mclk;

    hrs_host_resp #(.IOQ_DEPTH(4)) i_hrs_host_resp (
        .i_mclk(i_mclk), .i_reset_n(i_reset_n),
        .i_req_valid(i_req_valid), .o_req_ready(req_ready),
        .i_first_request_phase_code(code_a), .i_second_request_phase_code(code_b),
        .i_second_phase_type_byte(type_byte), .i_protected_space_qualifier(qual),
        .i_req_read(at[9]), .i_req_write(at[8]), .i_req_zero_len(at[7]),
        .i_req_io(at[6]), .i_req_hub(at[5]), .i_req_gfx(at[4]), .i_req_locked(at[3]),
        .i_req_busy(at[2]), .i_req_defer(at[1]), .i_snoop_hitm(at[0]),
        .i_read_data_ready(data_ready),
        .o_resp_valid(resp_valid), .o_response_status_code(rs_code),
        .o_resp_protected(resp_prot),
        .o_hub_sc_valid(sc_valid), .o_hub_sc_kind(sc_kind),
        .i_hub_sc_ready(sc_ready), .i_hub_master_abort(abort),
        .o_protected_management_mode(mode)
    );

    hrs_hub_model i_hrs_hub_model (
        .i_mclk(i_mclk), .i_slow(slow), .i_sc_valid(sc_valid), .i_sc_kind(sc_kind),
        .o_sc_ready(sc_ready), .o_master_abort(abort), .o_taken(taken),
        .o_kind_seen(kind_seen)
    );

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic compare(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tick();
        @(posedge i_mclk);
        #5;
    endtask

    // leaves valid high so that back-to-back offers need no gap
    task automatic send(input logic [4:0] a, input logic [4:0] b, input logic [7:0] ty,
                        input logic q, input logic [9:0] attr);
        int n;
        code_a = a;
        code_b = b;
        type_byte = ty;
        qual = q;
        at = attr;
        i_req_valid = 1'b1;
        n = 0;
        while (req_ready !== 1'b1) begin
            tick();
            n++;
            if (n > 40) begin
                fail_count++;
                wrap_up();
            end
        end
        tick();
    endtask

    task automatic wait_resp(input logic [2:0] exp_code, input logic exp_prot);
        int n;
        i_req_valid = 1'b0;
        n = 0;
        while (1) begin
            tick();
            if (resp_valid === 1'b1) begin
                compare(rs_code, exp_code);
                compare(resp_prot, exp_prot);
                return;
            end
            n++;
            if (n > 40) begin
                fail_count++;
                wrap_up();
            end
        end
    endtask

    task automatic sc_check_codes();
        logic [9:0] attrs [11] = '{10'b1000000000, 10'b0100000000, 10'b1010000000,
            10'b1000000001, 10'b1000100100, 10'b0100100100, 10'b1000001100,
            10'b1001100010, 10'b0101010010, 10'b0100010010, 10'b1000010100};
        logic [2:0] exp [11] = '{3'h7, 3'h5, 3'h5, 3'h6, 3'h1, 3'h1, 3'h1, 3'h2, 3'h2,
            3'h5, 3'h7};
        for (int i = 0; i < 11; i++) begin
            send(5'h10, 5'h00, 8'h00, 1'b0, attrs[i]);
            wait_resp(exp[i], 1'b0);
        end
    endtask

    // second phase needs only low bits 001; 0x08/0x00 is not special
    task automatic sc_special_types();
        logic [7:0] ty [10] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h2a,
            8'hff, 8'h08};
        logic [1:0] kind [10] = '{2'h0, 2'h1, 2'h0, 2'h2, 2'h0, 2'h0, 2'h3, 2'h0, 2'h0,
            2'h0};
        logic [7:0] n0;
        for (int i = 0; i < 10; i++) begin
            slow = i[0];
            n0 = taken;
            send(5'h08, (i[1] ? 5'h19 : 5'h01), ty[i], 1'b0, 10'b1000000000);
            wait_resp(3'h5, 1'b0);
            compare(taken - n0, (kind[i] != 2'h0));
            if (kind[i] != 2'h0) begin
                compare(kind_seen, kind[i]);
                compare(sc_kind, kind[i]);
                compare(sc_valid, 1'b0);
            end
            compare(mode, 1'b0);
        end
        n0 = taken;
        send(5'h08, 5'h00, 8'h01, 1'b0, 10'b1000100000);
        wait_resp(3'h7, 1'b0);
        compare(taken, n0);
    endtask

    task automatic sc_protected_mode();
        send(5'h08, 5'h01, 8'h07, 1'b1, 10'h000);
        wait_resp(3'h5, 1'b0);
        compare(mode, 1'b1);
        send(5'h10, 5'h00, 8'h00, 1'b1, 10'b0100000000);
        wait_resp(3'h5, 1'b1);
        send(5'h10, 5'h00, 8'h00, 1'b0, 10'b0100000000);
        wait_resp(3'h5, 1'b0);
        send(5'h08, 5'h01, 8'h07, 1'b0, 10'h000);
        wait_resp(3'h5, 1'b0);
        compare(mode, 1'b0);
        send(5'h10, 5'h00, 8'h00, 1'b1, 10'b0100000000);
        wait_resp(3'h5, 1'b0);
    endtask

    // blocked read at the head fills the queue behind it
    task automatic sc_queue_order();
        data_ready = 1'b0;
        send(5'h10, 5'h00, 8'h00, 1'b0, 10'b1000000000);
        send(5'h10, 5'h00, 8'h00, 1'b0, 10'b0100000000);
        send(5'h10, 5'h00, 8'h00, 1'b0, 10'b1000000001);
        send(5'h10, 5'h00, 8'h00, 1'b0, 10'b0100000000);
        compare(req_ready, 1'b0);
        i_req_valid = 1'b0;
        repeat (3) tick();
        compare(resp_valid, 1'b0);
        compare(req_ready, 1'b0);
        data_ready = 1'b1;
        wait_resp(3'h7, 1'b0);
        wait_resp(3'h5, 1'b0);
        wait_resp(3'h6, 1'b0);
        wait_resp(3'h5, 1'b0);
        compare(req_ready, 1'b1);
    endtask

    initial begin
        repeat (3) @(posedge i_mclk);
        #5 i_reset_n = 1'b1;
        repeat (3) tick();
        compare(req_ready, 1'b1);
        compare({resp_valid, rs_code, sc_valid, mode}, 6'h00);
        sc_check_codes();
        sc_special_types();
        sc_protected_mode();
        sc_queue_order();
        wrap_up();
    end
endmodule
`default_nettype wire
